// ### dv/rsd_mem_model.sv
// rsd_mem_model: buffer memory behind the remote dma and status write paths.
// assumes rsd_core on pclk; a word never stored reads as an address pattern.
module rsd_mem_model (
  input  wire logic        pclk,
  input  wire logic        status_wr,
  input  wire logic [15:0] status_addr,
  input  wire logic [7:0]  status_data,
  input  wire logic        rdma_stb,
  input  wire logic        rdma_wr,
  input  wire logic [15:0] rdma_addr,
  input  wire logic [15:0] rdma_wdata,
  output logic      [15:0] rdma_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // storage
  // ****
  logic [15:0] mem [65536];
  logic        vld [65536];
  // answers at once; a pattern, not zero, so a stale or unloaded address shows
  assign rdma_rdata = (vld[rdma_addr] === 1'b1) ? mem[rdma_addr] : rdma_addr ^ 16'h5AA5;
  always @(posedge pclk) begin
    if (rdma_stb && rdma_wr) begin
      mem[rdma_addr] <= rdma_wdata;
      vld[rdma_addr] <= 1'b1;
    end
    if (status_wr) begin
      mem[status_addr] <= {8'h00, status_data};
      vld[status_addr] <= 1'b1;
    end
  end
endmodule

// ### dv/testbench.sv
// testbench: self-checking bench of rsd_core with a buffer memory model.
// assumes zero or more apb wait states; expected reads and status writes queued.
module testbench;
  import rsd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // signals and checking
  // ****
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        fst, bv, bt, fen, fov, crs, txs, ls, nb, rx_abort, status_wr, rdma_stb, rdma_wr;
  logic [7:0]  paddr, status_data, r;
  logic [31:0] pwdata, prdata, crc;
  logic [15:0] lcl_addr, tx_length, status_addr, rdma_addr, rdma_wdata, rdma_rdata, a;
  logic [47:0] da, ma;
  logic [32:0] rq[$];
  logic [23:0] sq[$];
  int          error_cnt, total_checks, h, n, dr;
  rsd_core uut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pready, .prdata,
    .pslverr, .rx_frame_start(fst), .rx_bit_valid(bv), .rx_bit(bt), .rx_frame_end(fen),
    .fifo_overflow(fov), .rx_no_buffer(nb), .carrier_sense(crs), .collision(1'b0),
    .jabber_hold(1'b0), .lcl_byte_stb(ls), .tx_start(txs), .lcl_addr, .tx_length, .rx_abort,
    .status_wr, .status_addr, .status_data, .rdma_stb, .rdma_wr, .rdma_addr, .rdma_wdata, .rdma_rdata);
  rsd_mem_model mdl (.pclk, .status_wr, .status_addr, .status_data, .rdma_stb, .rdma_wr,
    .rdma_addr, .rdma_wdata, .rdma_rdata);
  task automatic chk(input logic c, input string m);
    total_checks++;
    if (c !== 1'b1) begin
      error_cnt++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task automatic print_verdict;
    chk(rq.size() == 0 && sq.size() == 0, "outstanding notes");
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // oldest note against each answer; an answer with no note is itself a mismatch
  always @(posedge pclk) begin
    if (psel && penable && !pwrite && pready === 1'b1)
      chk(rq.size() > 0 && {pslverr, prdata} === rq.pop_front(), "read data");
    if (status_wr === 1'b1)
      chk(sq.size() > 0 && {status_addr, status_data} === sq.pop_front(), "status write");
  end
  task automatic apb(input logic w, input logic [5:0] ix, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= {ix, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 64);
    if (k >= 64) begin
      error_cnt++;
      print_verdict;
    end
    psel <= 0;
    penable <= 0;
  endtask
  task automatic wr(input logic [5:0] ix, input logic [31:0] d);
    apb(1, ix, d);
  endtask
  task automatic rd(input logic [5:0] ix, input logic [32:0] e);
    rq.push_back(e);
    apb(0, ix, 0);
  endtask
  function automatic logic [31:0] stp(input logic [31:0] c, input logic b);
    return {c[30:0], 1'b0} ^ ((c[31] ^ b) ? CRC_POLY : 32'h0);
  endfunction
  function automatic int hsh(input logic [47:0] d);
    logic [31:0] c;
    c = CRC_INIT;
    for (int i = 0; i < 48; i++) c = stp(c, d[i]);
    return c[31:26];
  endfunction
  task automatic sb(input logic b);
    @(posedge pclk);
    bv <= 1;
    bt <= b;
    crc = stp(crc, b);
  endtask
  // whole frame: 48 dest bits, 16 payload bits, fcs, then dr dribble bits
  task automatic frm(input logic [47:0] d, input logic bad);
    logic [31:0] f;
    crc = CRC_INIT;
    @(posedge pclk) fst <= 1;
    @(posedge pclk) fst <= 0;
    for (int i = 0; i < 64; i++) sb(i < 48 ? d[i] : 1'($urandom));
    f = ~crc ^ {31'h0, bad};
    for (int i = 31; i >= 0; i--) sb(f[i]);
    repeat (dr) sb(1'b1);
    @(posedge pclk) bv <= 0;
    fen <= 1;
    @(posedge pclk) fen <= 0;
    repeat (3) @(posedge pclk);
  endtask
  initial begin
    pclk = 0;
    forever #2 pclk = ~pclk;
  end
  initial begin
    repeat (30000) @(posedge pclk);
    error_cnt++;
    print_verdict;
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, fst, bv, bt, fen, fov, crs, txs, ls, nb} = '0;
    error_cnt = 0;
    total_checks = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1;
    void'($urandom(32'h95B4));
    wr(IX_RING_1ST, 'h40);
    wr(IX_RING_END, 'h60);
    wr(IX_RD_PAGE, 'h5F);
    wr(IX_WR_PAGE, 'h40);
    da = {$urandom, $urandom} & ~48'h1;
    for (int i = 0; i < 6; i++) wr(IX_STA0 + i, da[8*i+:8]);
    wr(IX_RX_CFG, 'h04);
    rd(IX_RING_END, 'h60);
    wr(IX_LDA_H, 'hFF);
    rd(IX_LDA_H, 0);
    rd(6'h3F, 33'h100000000);
    r = $urandom;
    a = $urandom;
    wr(IX_TX_PAGE, r);
    wr(IX_TX_LEN_L, a[7:0]);
    wr(IX_TX_LEN_H, a[15:8]);
    @(posedge pclk) txs <= 1;
    @(posedge pclk) txs <= 0;
    @(posedge pclk);
    chk(lcl_addr === {r, 8'h00}, "tx start address");
    chk(tx_length === a, "tx length");
    rd(IX_LDA_H, r);
    rd(IX_TX_LEN_H, a[15:8]);
    $display("test registers and transmit done");
    sq.push_back({16'h4000, 8'h01});
    frm(da, 0);
    rd(IX_RX_STAT, 'h01);
    frm(da, 1);
    rd(IX_RX_STAT, 'h02);
    rd(IX_T_CRC, 1);
    ma = {$urandom, $urandom} | 48'h1;
    h = hsh(ma);
    wr(IX_HASH0 + h / 8, 1 << (h % 8));
    sq.push_back({16'h4100, 8'h21});
    frm(ma, 0);
    wr(IX_RX_CFG, 'h14);
    crs <= 1;
    rd(IX_RX_STAT, 'hE1);
    wr(IX_RX_CFG, 'h04);
    crs <= 0;
    wr(IX_HASH0 + h / 8, 0);
    frm(ma, 0);
    $display("test receive and filter done");
    @(posedge pclk) fst <= 1;
    @(posedge pclk) fst <= 0;
    repeat (10) sb(1);
    @(posedge pclk) fov <= 1;
    bv <= 0;
    @(posedge pclk) fov <= 0;
    #1;
    n = 0;
    while (rx_abort !== 1'b1 && n < 8) begin
      @(posedge pclk);
      #1;
      n++;
    end
    chk(n < 8, "overflow abort");
    rd(IX_RX_STAT, 'h08);
    $display("test overflow done");
    a = $urandom & 16'h3F7E;
    r = $urandom;
    wr(IX_RS_L, a[7:0]);
    wr(IX_RS_H, a[15:8]);
    wr(IX_RL_L, 4);
    wr(IX_RL_H, 0);
    wr(IX_RD_CTRL, 3);
    rd(IX_DPORT, a ^ 16'h5AA5);
    wr(IX_DPORT, {r, ~r});
    rd(IX_RA_L, 8'(a + 16'h4));
    rd(IX_RA_H, a[15:8]);
    wr(IX_RS_L, a[7:0] + 2);
    wr(IX_RL_L, 1);
    wr(IX_RD_CTRL, 1);
    rd(IX_DPORT, {r, ~r});
    rd(IX_RA_L, a[7:0] + 3);
    $display("test remote dma done");
    wr(IX_RD_PAGE, 'h41);
    @(posedge pclk) fst <= 1;
    @(posedge pclk) fst <= 0;
    ls <= 1;
    repeat (7676) @(posedge pclk);
    #1 chk(lcl_addr === 16'h4000, "ring wrap");
    repeat (256) @(posedge pclk);
    ls <= 0;
    #1 chk(rx_abort === 1'b1 && lcl_addr === 16'h4204, "ring full");
    rd(IX_RX_STAT, 'h10);
    nb <= 1;
    frm(da, 0);
    nb <= 0;
    rd(IX_RX_STAT, 'h10);
    rd(IX_T_MISS, 2);
    dr = 3;
    frm(da, 1);
    dr = 0;
    rd(IX_RX_STAT, 'h06);
    rd(IX_T_ALIGN, 1);
    rd(IX_T_CRC, 2);
    $display("test ring, missed and alignment done");
    repeat (4) @(posedge pclk);
    print_verdict;
  end
endmodule

// ### rtl/rsd_core.sv
// rsd_core: receive status, dma page pointers, remote dma and address filter.
// assumes receive bits, frame marks and byte strobes come from mac logic on pclk.
//
// Summary of operation
// - status byte goes to memory after kept packets; rejected errored packets write none
// - status clears when a frame starts; bits 5:0 read zero from reset until the first frame
// - bit 0 set only when crc, alignment, overflow and missed are all clear
// - bit 1 marks crc error, also on alignment error; counts a tally
// - bit 2 marks odd-bit end with bad crc; counts alignment tally
// - bit 3 marks fifo overflow; the frame is aborted
// - bit 4 marks a frame for us not buffered; counts missed tally
// - bit 5 is 0 for physical match, 1 for multicast or broadcast
// - bit 6 follows monitor mode, receiver disabled
// - bit 7 shows carrier sense or collision, held by jabber
// - every register but the 16-bit data port is an 8-bit location; 16-bit values split low/high
// - transmit start with receive idle loads page base into address high byte, low byte zero
// - transmit length is full 16 bits, never truncated
// - ring first and end registers hold page numbers only
// - next page equal to read page aborts local dma
// - write page restores local dma after a receive error
// - current local and remote dma addresses readable as two bytes
// - remote start and length loaded from low and high bytes
// - remote step is two in word mode, one in byte mode
// - destination compared with six station bytes, byte by byte
// - last destination bit latches six crc bits indexing the hash filter
// - crc uses the standard 32-bit ethernet polynomial
// - local address reaching ring end page wraps to ring first page
module rsd_core
  import rsd_pkg::*;
#(
  parameter int TALLY_W = 8
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic      [31:0]       prdata,
  output logic                   pslverr,
  input  wire logic              rx_frame_start,
  input  wire logic              rx_bit_valid,
  input  wire logic              rx_bit,
  input  wire logic              rx_frame_end,
  input  wire logic              fifo_overflow,
  input  wire logic              rx_no_buffer,
  input  wire logic              carrier_sense,
  input  wire logic              collision,
  input  wire logic              jabber_hold,
  input  wire logic              lcl_byte_stb,
  input  wire logic              tx_start,
  output logic      [15:0]       lcl_addr,
  output logic      [15:0]       tx_length,
  output logic                   rx_abort,
  output logic                   status_wr,
  output logic      [15:0]       status_addr,
  output logic      [7:0]        status_data,
  output logic                   rdma_stb,
  output logic                   rdma_wr,
  output logic      [15:0]       rdma_addr,
  output logic      [15:0]       rdma_wdata,
  input  wire logic [15:0]       rdma_rdata
);

  // ********************************
  // declarations
  // ********************************
  logic [7:0]         cfg_q, txp_q, txl_lo_q, txl_hi_q, rf_q, re_q, rp_q, wp_q;
  logic [7:0]         rs_lo_q, rs_hi_q, rl_lo_q, rl_hi_q;
  logic [7:0]         station_q [STATION_N];
  logic [7:0]         hash_q [HASH_N];
  logic [63:0]        hash_bits;
  logic [STATION_N-1:0] byte_eq;
  logic [15:0]        la_q, ra_q, rc_q;
  logic               word_q;
  logic [5:0]         st_q;
  logic [TALLY_W-1:0] t_al_q, t_crc_q, t_miss_q;
  rsd_rx_state_t      rx_q;
  logic [5:0]         dcnt_q, hidx_q;
  logic [2:0]         ph_q;
  logic [47:0]        da_q;
  logic               ok_q;
  logic [31:0]        crc_nx, rd_w, prdata_q;
  logic [IDX_W-1:0]   idx, sta_off, hash_off;
  logic               hit, acc, wr_en, sta_sel, hash_sel, dport;
  logic               start, bit_go, ovf, lnk, ring_full, abort, fend;
  logic               crc_e, fae, mc, bc, match, miss, keep;
  logic [7:0]         nxp, sb;
  logic [15:0]        step;
  logic               abort_q, swr_q;
  logic [15:0]        saddr_q;
  logic [7:0]         sdata_q;

  function automatic logic [7:0] next_page(input logic [7:0] p, input logic [7:0] first,
                                            input logic [7:0] last);
    logic [7:0] n;
    n = p + 8'h01;
    return (n == last) ? first : n;
  endfunction

  // ********************************
  // apb slave
  // ********************************
  assign idx      = paddr[ADDR_W-1:2];
  assign acc      = psel & penable;
  assign wr_en    = acc & pwrite;
  assign sta_off  = idx - IX_STA0;
  assign hash_off = idx - IX_HASH0;
  assign sta_sel  = (idx >= IX_STA0) && (idx < IX_STA_END);
  assign hash_sel = (idx >= IX_HASH0) && (idx < IX_HASH_END);
  assign dport    = acc && (idx == IX_DPORT);
  // zero wait states; read data is caught in the setup cycle
  assign pready   = 1'b1;
  assign pslverr  = acc & ~hit;
  assign prdata   = prdata_q;

  // 8-bit registers sit in the low lane, upper bits read zero
  always_comb begin
    rd_w = 32'h00000000;
    hit  = 1'b1;
    case (idx)
      IX_RX_CFG:   rd_w[7:0] = cfg_q;
      IX_TX_PAGE:  rd_w[7:0] = txp_q;
      IX_TX_LEN_L: rd_w[7:0] = txl_lo_q;
      IX_TX_LEN_H: rd_w[7:0] = txl_hi_q;
      IX_RX_STAT:  rd_w[7:0] = {carrier_sense | collision | jabber_hold,
                                cfg_q[CF_MONITR], st_q};
      IX_RING_1ST: rd_w[7:0] = rf_q;
      IX_RING_END: rd_w[7:0] = re_q;
      IX_RD_PAGE:  rd_w[7:0] = rp_q;
      IX_WR_PAGE:  rd_w[7:0] = wp_q;
      IX_LDA_L:    rd_w[7:0] = la_q[7:0];
      IX_LDA_H:    rd_w[7:0] = la_q[15:8];
      IX_RS_L:     rd_w[7:0] = rs_lo_q;
      IX_RS_H:     rd_w[7:0] = rs_hi_q;
      IX_RL_L:     rd_w[7:0] = rl_lo_q;
      IX_RL_H:     rd_w[7:0] = rl_hi_q;
      IX_RA_L:     rd_w[7:0] = ra_q[7:0];
      IX_RA_H:     rd_w[7:0] = ra_q[15:8];
      IX_RD_CTRL:  rd_w[7:0] = {6'h00, word_q, 1'b0};
      IX_DPORT:    rd_w[15:0] = rdma_rdata;
      IX_T_ALIGN:  rd_w[TALLY_W-1:0] = t_al_q;
      IX_T_CRC:    rd_w[TALLY_W-1:0] = t_crc_q;
      IX_T_MISS:   rd_w[TALLY_W-1:0] = t_miss_q;
      default: begin
        if (sta_sel) begin
          rd_w[7:0] = station_q[sta_off[2:0]];
        end else if (hash_sel) begin
          rd_w[7:0] = hash_q[hash_off[2:0]];
        end else begin
          hit = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata_q <= rd_w;
    end
  end

  // ********************************
  // host registers
  // ********************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q    <= 8'h00;
      txp_q    <= 8'h00;
      txl_lo_q <= 8'h00;
      txl_hi_q <= 8'h00;
      rf_q     <= 8'h00;
      re_q     <= 8'h00;
      rp_q     <= 8'h00;
      rs_lo_q  <= 8'h00;
      rs_hi_q  <= 8'h00;
      rl_lo_q  <= 8'h00;
      rl_hi_q  <= 8'h00;
    end else if (wr_en) begin
      case (idx)
        IX_RX_CFG:   cfg_q    <= pwdata[7:0];
        IX_TX_PAGE:  txp_q    <= pwdata[7:0];
        IX_TX_LEN_L: txl_lo_q <= pwdata[7:0];
        IX_TX_LEN_H: txl_hi_q <= pwdata[7:0];
        IX_RING_1ST: rf_q     <= pwdata[7:0];
        IX_RING_END: re_q     <= pwdata[7:0];
        IX_RD_PAGE:  rp_q     <= pwdata[7:0];
        IX_RS_L:     rs_lo_q  <= pwdata[7:0];
        IX_RS_H:     rs_hi_q  <= pwdata[7:0];
        IX_RL_L:     rl_lo_q  <= pwdata[7:0];
        IX_RL_H:     rl_hi_q  <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // no truncation: all 16 bits pass to the transmitter
  assign tx_length = {txl_hi_q, txl_lo_q};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < STATION_N; i++) station_q[i] <= 8'h00;
      for (int i = 0; i < HASH_N; i++) hash_q[i] <= 8'h00;
    end else if (wr_en) begin
      for (int i = 0; i < STATION_N; i++) begin
        if (sta_sel && sta_off[2:0] == 3'(i)) station_q[i] <= pwdata[7:0];
      end
      for (int i = 0; i < HASH_N; i++) begin
        if (hash_sel && hash_off[2:0] == 3'(i)) hash_q[i] <= pwdata[7:0];
      end
    end
  end

  // ********************************
  // address filter
  // ********************************
  genvar g;
  generate
    for (g = 0; g < STATION_N; g++) begin : g_sta
      assign byte_eq[g] = (da_q[8*g +: 8] == station_q[g]);
    end
    for (g = 0; g < HASH_N; g++) begin : g_hash
      assign hash_bits[8*g +: 8] = hash_q[g];
    end
  endgenerate

  assign mc    = da_q[0];
  assign bc    = &da_q;
  // promiscuous only widens the physical case
  assign match = mc ? (bc ? cfg_q[CF_BCAST] : (cfg_q[CF_MCAST] & hash_bits[hidx_q]))
                    : ((&byte_eq) | cfg_q[CF_PROMIS]);

  // ********************************
  // receive sequencing
  // ********************************
  assign start     = rx_frame_start && (rx_q == RSD_IDLE);
  assign bit_go    = rx_bit_valid && (rx_q != RSD_IDLE);
  assign ovf       = fifo_overflow && (rx_q != RSD_IDLE);
  assign nxp       = next_page(la_q[15:8], rf_q, re_q);
  assign lnk       = lcl_byte_stb && (rx_q != RSD_IDLE) && (la_q[7:0] == PAGE_TOP);
  assign ring_full = lnk && (nxp == rp_q);
  assign abort     = ovf | ring_full;
  assign fend      = rx_frame_end && (rx_q == RSD_BODY) && !abort;
  // six or more dribble bits are treated as misaligned even with good crc
  assign crc_e     = !ok_q || (ph_q >= DRIB_LIM);
  assign fae       = (ph_q != 3'h0) && crc_e;
  assign miss      = match && (rx_no_buffer || cfg_q[CF_MONITR]);
  assign keep      = match && !miss && (!crc_e || cfg_q[CF_SAVE]);
  assign sb        = {2'b00, mc, miss, 1'b0, fae, crc_e | fae,
                      !(crc_e || fae || miss)};

  rsd_crc32 u_crc (
    .pclk    (pclk),
    .presetn (presetn),
    .init    (start),
    .en      (bit_go),
    .din     (rx_bit),
    .crc_q   (),
    .crc_nx  (crc_nx)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_q   <= RSD_IDLE;
      dcnt_q <= 6'h00;
      ph_q   <= 3'h0;
      da_q   <= 48'h000000000000;
      hidx_q <= 6'h00;
      ok_q   <= 1'b0;
    end else if (start) begin
      rx_q   <= RSD_DEST;
      dcnt_q <= 6'h00;
      ph_q   <= 3'h0;
      ok_q   <= 1'b0;
    end else if (abort || fend) begin
      rx_q <= RSD_IDLE;
    end else if (bit_go) begin
      ph_q <= ph_q + 3'h1;
      if (ph_q == 3'h7) ok_q <= (crc_nx == CRC_RESIDUE);
      unique case (rx_q)
        RSD_DEST: begin
          da_q   <= {rx_bit, da_q[47:1]};
          dcnt_q <= dcnt_q + 6'h01;
          if (dcnt_q == DA_LAST) begin
            hidx_q <= crc_nx[31:26];
            rx_q   <= RSD_BODY;
          end
        end
        RSD_BODY: ;
        default: rx_q <= RSD_IDLE;
      endcase
    end
  end

  // ********************************
  // status and tallies
  // ********************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= 6'h00;
    end else if (start) begin
      st_q <= 6'h00;
    end else if (fend) begin
      st_q <= sb[5:0];
    end else begin
      if (ovf) st_q[ST_FIFO] <= 1'b1;
      if (ring_full) st_q[ST_MISSED] <= 1'b1;
    end
  end

  // counters saturate so a slow host sees a full scale, not a wrap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t_al_q   <= '0;
      t_crc_q  <= '0;
      t_miss_q <= '0;
    end else begin
      if (fend && fae && !(&t_al_q)) t_al_q <= t_al_q + 1'b1;
      if (fend && crc_e && !(&t_crc_q)) t_crc_q <= t_crc_q + 1'b1;
      if (((fend && miss) || ring_full) && !(&t_miss_q)) t_miss_q <= t_miss_q + 1'b1;
    end
  end

  // ********************************
  // local dma pointers
  // ********************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      la_q <= 16'h0000;
    end else if (tx_start && rx_q == RSD_IDLE) begin
      la_q <= {txp_q, PAGE_LOW};
    end else if (start || abort || (fend && !keep)) begin
      la_q <= {wp_q, HDR_BYTES};
    end else if (lcl_byte_stb) begin
      la_q <= lnk ? {nxp, PAGE_LOW} : la_q + 16'h0001;
    end
  end

  // the host is expected to program this once from ring first page
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_q <= 8'h00;
    end else if (fend && keep) begin
      wp_q <= nxp;
    end else if (wr_en && idx == IX_WR_PAGE) begin
      wp_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      abort_q <= 1'b0;
      swr_q   <= 1'b0;
      saddr_q <= 16'h0000;
      sdata_q <= 8'h00;
    end else begin
      abort_q <= abort;
      swr_q   <= fend && keep;
      if (fend) begin
        saddr_q <= {wp_q, PAGE_LOW};
        sdata_q <= {carrier_sense | collision | jabber_hold, cfg_q[CF_MONITR], sb[5:0]};
      end
    end
  end

  assign lcl_addr    = la_q;
  assign rx_abort    = abort_q;
  assign status_wr   = swr_q;
  assign status_addr = saddr_q;
  assign status_data = sdata_q;

  // ********************************
  // remote dma
  // ********************************
  assign step       = word_q ? STEP_WORD : STEP_BYTE;
  assign rdma_stb   = dport && (rc_q != 16'h0000);
  assign rdma_wr    = pwrite;
  assign rdma_addr  = ra_q;
  assign rdma_wdata = pwdata[15:0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ra_q   <= 16'h0000;
      rc_q   <= 16'h0000;
      word_q <= 1'b0;
    end else if (wr_en && idx == IX_RD_CTRL && pwdata[RC_START]) begin
      ra_q   <= {rs_hi_q, rs_lo_q};
      rc_q   <= {rl_hi_q, rl_lo_q};
      word_q <= pwdata[RC_WORD];
    end else if (rdma_stb) begin
      ra_q <= ra_q + step;
      rc_q <= (rc_q < step) ? 16'h0000 : rc_q - step;
    end
  end

  // ********************************
  // assertions
  // ********************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_start;
    rx_frame_start && rx_q == RSD_IDLE;
  endsequence

  sequence s_dest_last;
    bit_go && rx_q == RSD_DEST && dcnt_q == DA_LAST && !abort;
  endsequence

  status_clear_a: assert property (s_start |=> st_q == 6'h00 && rx_q == RSD_DEST)
    else $error("status not cleared at frame start");
  intact_set_a: assert property (fend && !crc_e && !miss |=> st_q[ST_INTACT] && !st_q[ST_CRC])
    else $error("intact flag wrong on good frame");
  align_crc_a: assert property (fend && fae |=> st_q[ST_ALIGN] && st_q[ST_CRC])
    else $error("alignment error without crc error");
  overflow_abort_a: assert property (ovf |=> rx_abort && st_q[ST_FIFO] && rx_q == RSD_IDLE)
    else $error("overflow did not abort");
  tx_load_a: assert property (tx_start && rx_q == RSD_IDLE |=> la_q == {$past(txp_q), PAGE_LOW})
    else $error("transmit page not loaded");
  ring_full_a: assert property (ring_full |=> rx_abort && la_q == {$past(wp_q), HDR_BYTES})
    else $error("ring overflow not aborted");
  ring_wrap_a: assert property (lnk && !abort && !fend && !tx_start |=> la_q[7:0] == PAGE_LOW
    && la_q[15:8] != re_q) else $error("local address passed ring end");
  remote_step_a: assert property (rdma_stb && word_q |=> ra_q == $past(ra_q) + STEP_WORD)
    else $error("remote word step wrong");
  hash_latch_a: assert property (s_dest_last |=> hidx_q == $past(crc_nx[31:26]) ##0 rx_q == RSD_BODY)
    else $error("hash index not latched");
  status_wr_a: assert property (fend && keep |=> status_wr && status_addr == {$past(wp_q), PAGE_LOW})
    else $error("status write missing");

endmodule

// ### rtl/rsd_crc32.sv
// rsd_crc32: serial frame check generator, one bit per enable.
// assumes bits arrive in wire order, first bit of the destination first.
module rsd_crc32
  import rsd_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        init,
  input  wire logic        en,
  input  wire logic        din,
  output logic      [31:0] crc_q,
  output logic      [31:0] crc_nx
);

  logic fb;

  assign fb     = crc_q[31] ^ din;
  // the standard 32-bit ethernet polynomial, shifted msb first
  assign crc_nx = {crc_q[30:0], 1'b0} ^ (fb ? CRC_POLY : 32'h00000000);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crc_q <= CRC_INIT;
    end else if (init) begin
      crc_q <= CRC_INIT;
    end else if (en) begin
      crc_q <= crc_nx;
    end
  end

endmodule

// ### rtl/rsd_pkg.sv
// rsd_pkg: register indices, field positions and constants of the receive
// status, dma pointer and address filter block.
// assumes a 32-bit apb master; every register is one aligned word.
package rsd_pkg;

  // ********************************
  // register map (word index)
  // ********************************
  localparam int              ADDR_W      = 8;
  localparam int              IDX_W       = 6;
  localparam int              STATION_N   = 6;
  localparam int              HASH_N      = 8;
  localparam logic [IDX_W-1:0] IX_RX_CFG   = 6'h00;
  localparam logic [IDX_W-1:0] IX_TX_PAGE  = 6'h01;
  localparam logic [IDX_W-1:0] IX_TX_LEN_L = 6'h02;
  localparam logic [IDX_W-1:0] IX_RX_STAT  = 6'h03;
  localparam logic [IDX_W-1:0] IX_TX_LEN_H = 6'h04;
  localparam logic [IDX_W-1:0] IX_RING_1ST = 6'h05;
  localparam logic [IDX_W-1:0] IX_RING_END = 6'h06;
  localparam logic [IDX_W-1:0] IX_RD_PAGE  = 6'h07;
  localparam logic [IDX_W-1:0] IX_WR_PAGE  = 6'h08;
  localparam logic [IDX_W-1:0] IX_LDA_L    = 6'h09;
  localparam logic [IDX_W-1:0] IX_LDA_H    = 6'h0A;
  localparam logic [IDX_W-1:0] IX_RS_L     = 6'h0B;
  localparam logic [IDX_W-1:0] IX_RS_H     = 6'h0C;
  localparam logic [IDX_W-1:0] IX_RL_L     = 6'h0D;
  localparam logic [IDX_W-1:0] IX_RL_H     = 6'h0E;
  localparam logic [IDX_W-1:0] IX_RA_L     = 6'h0F;
  localparam logic [IDX_W-1:0] IX_RA_H     = 6'h10;
  localparam logic [IDX_W-1:0] IX_RD_CTRL  = 6'h11;
  localparam logic [IDX_W-1:0] IX_DPORT    = 6'h12;
  localparam logic [IDX_W-1:0] IX_T_ALIGN  = 6'h13;
  localparam logic [IDX_W-1:0] IX_T_CRC    = 6'h14;
  localparam logic [IDX_W-1:0] IX_T_MISS   = 6'h15;
  localparam logic [IDX_W-1:0] IX_STA0     = 6'h18;
  localparam logic [IDX_W-1:0] IX_STA_END  = 6'h1E;
  localparam logic [IDX_W-1:0] IX_HASH0    = 6'h20;
  localparam logic [IDX_W-1:0] IX_HASH_END = 6'h28;

  // ********************************
  // fields
  // ********************************
  localparam int ST_INTACT = 0;
  localparam int ST_CRC    = 1;
  localparam int ST_ALIGN  = 2;
  localparam int ST_FIFO   = 3;
  localparam int ST_MISSED = 4;
  localparam int ST_CLASS  = 5;
  localparam int CF_SAVE   = 0;
  localparam int CF_BCAST  = 1;
  localparam int CF_MCAST  = 2;
  localparam int CF_PROMIS = 3;
  localparam int CF_MONITR = 4;
  localparam int RC_START  = 0;
  localparam int RC_WORD   = 1;

  // ********************************
  // constants
  // ********************************
  localparam logic [31:0] CRC_POLY    = 32'h04C11DB7;
  localparam logic [31:0] CRC_INIT    = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_RESIDUE = 32'hC704DD7B;
  localparam logic [5:0]  DA_LAST     = 6'h2F;
  localparam logic [2:0]  DRIB_LIM    = 3'h6;
  localparam logic [7:0]  HDR_BYTES   = 8'h04;
  localparam logic [7:0]  PAGE_LOW    = 8'h00;
  localparam logic [7:0]  PAGE_TOP    = 8'hFF;
  localparam logic [15:0] STEP_WORD   = 16'h0002;
  localparam logic [15:0] STEP_BYTE   = 16'h0001;

  typedef enum logic [1:0] {
    RSD_IDLE = 2'b00,
    RSD_DEST = 2'b01,
    RSD_BODY = 2'b10
  } rsd_rx_state_t;

endpackage
